// *** bench/sroi_grabber_sink.sv ***
/*
  Frame grabber stand-in: tallies pixels, rows and frames leaving the
  selector and keeps the first and last pixel of the latest frame.
  Assumes one output pixel per out_valid cycle on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module sroi_grabber_sink #(
  parameter int PIX_W = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             out_valid,
  input  wire logic             out_frame_start,
  input  wire logic             out_line_start,
  input  wire logic [PIX_W-1:0] out_data,
  output logic      [15:0]      pix_count,
  output logic      [15:0]      row_count,
  output logic      [15:0]      frame_count,
  output logic      [PIX_W-1:0] first_data,
  output logic      [PIX_W-1:0] last_data
);
  // A frame start reopens the pixel and row tallies, so each frame is judged as one image.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pix_count   <= 16'h0000;
      row_count   <= 16'h0000;
      frame_count <= 16'h0000;
      first_data  <= '0;
      last_data   <= '0;
    end
    else if (out_valid && out_frame_start)
    begin
      pix_count   <= 16'h0001;
      row_count   <= 16'h0001;
      frame_count <= frame_count + 16'h0001;
      first_data  <= out_data;
      last_data   <= out_data;
    end
    else if (out_valid)
    begin
      pix_count <= pix_count + 16'h0001;
      row_count <= row_count + {15'h0000, out_line_start};
      last_data <= out_data;
    end
  end
endmodule : sroi_grabber_sink
`default_nettype wire

// *** bench/sroi_window_select_tb_top.sv ***
/*
  Self-checking bench for the window and band selector: APB register
  tests and whole raster frames on a small 128 by 8 sensor.
  Assumes an APB slave on clk_sys, with any number of wait states, and one
  pixel per valid.
*/
`timescale 1ns/1ps
`default_nettype none
module sroi_window_select_tb_top;
  import sroi_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, ok, act;
  logic        pix_valid = 1'b0, pix_frame_start = 1'b0, pix_line_start = 1'b0;
  logic [11:0] pix_data = 12'h000, out_data, first_data, last_data;
  logic        out_valid, out_frame_start, out_line_start;
  logic [15:0] pix_count, row_count, frame_count;
  int          checks = 0;
  int          bad_count = 0;

  // 20 MHz system clock.
  always #25 clk_sys = ~clk_sys;

  sroi_window_select #(.PIX_W(12), .EFF_COLS(16'h0080), .EFF_ROWS(16'h0008)) i_sroi_window_select (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .pix_frame_start(pix_frame_start),
    .pix_line_start(pix_line_start), .pix_data(pix_data), .out_valid(out_valid),
    .out_frame_start(out_frame_start), .out_line_start(out_line_start),
    .out_data(out_data), .band_settings_ok(ok), .band_readout_active(act));

  sroi_grabber_sink #(.PIX_W(12)) i_sroi_grabber_sink (
    .clk_sys(clk_sys), .reset(reset), .out_valid(out_valid),
    .out_frame_start(out_frame_start), .out_line_start(out_line_start),
    .out_data(out_data), .pix_count(pix_count), .row_count(row_count),
    .frame_count(frame_count), .first_data(first_data), .last_data(last_data));

  // Compares with case equality so an unknown never counts as a match.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang.
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask : rd_chk

  // Sends a full 128 by 8 raster frame whose pixel value is its address,
  // then compares what the sink received.
  task automatic frame_chk(input logic [15:0] n, input logic [11:0] f, input logic [11:0] l);
    for (int y = 0; y < 8; y++)
      for (int x = 0; x < 128; x++)
      begin
        @(posedge clk_sys);
        pix_valid       <= 1'b1;
        pix_frame_start <= (y == 0 && x == 0);
        pix_line_start  <= (x == 0);
        pix_data        <= 12'(y * 128 + x);
      end
    @(posedge clk_sys);
    pix_valid       <= 1'b0;
    pix_frame_start <= 1'b0;
    pix_line_start  <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({16'h0000, pix_count}, {16'h0000, n});
    chk({16'h0000, row_count}, 32'h0000_0004);
    chk({20'h0_0000, first_data}, {20'h0_0000, f});
    chk({20'h0_0000, last_data}, {20'h0_0000, l});
  endtask : frame_chk

  // Prints the tallies and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Watchdog: the tests need well under 5000 cycles.
  initial
  begin
    repeat (10000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end

  // Main sequence: registers, a window frame, a band frame, illegal bands.
  initial
  begin
    logic [31:0] r;
    logic        e;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(A_WIN_COLS, 32'h0000_0080);
    rd_chk(A_WIN_ROWS, 32'h0000_0008);
    rd_chk(A_EFF_ROWS, 32'h0000_0008);
    rd_chk(A_BAND_STAT, 32'h0000_0000);
    wr(A_WIN_COLS, 32'h0000_005F);
    rd_chk(A_WIN_COLS, 32'h0000_0050);
    wr(A_WIN_COLS, 32'h0000_0025);
    rd_chk(A_WIN_COLS, 32'h0000_0040);
    wr(A_WIN_ROWS, 32'h0000_0007);
    rd_chk(A_WIN_ROWS, 32'h0000_0006);
    wr(A_WIN_ROWS, 32'h0000_0003);
    rd_chk(A_WIN_ROWS, 32'h0000_0004);
    wr(A_EFF_COLS, 32'h0000_0010);
    rd_chk(A_EFF_COLS, 32'h0000_0080);
    // Size is set before offsets, and size stays below the largest extent.
    wr(A_WIN_CS, 32'h0000_0010);
    wr(A_WIN_RS, 32'h0000_0002);
    rd_chk(A_LRG_COLS, 32'h0000_0070);
    rd_chk(A_LRG_ROWS, 32'h0000_0006);
    xfer(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    frame_chk(16'h0100, 12'h110, 12'h2CF);
    chk({31'h0000_0000, act}, 32'h0000_0000);
    wr(A_BAND_CMN, 32'h0000_002F);
    rd_chk(A_BAND_CMN, 32'h0000_0020);
    wr(A_BAND_SEL, 32'h0000_0000);
    wr(A_BAND_CS, 32'h0000_0035);
    wr(A_BAND_RS, 32'h0000_0004);
    wr(A_BAND_ROWS, 32'h0000_0003);
    wr(A_BAND_ON, 32'h0000_0001);
    rd_chk(A_BAND_ROWS, 32'h0000_0002);
    wr(A_BAND_SEL, 32'h0000_0001);
    wr(A_BAND_CS, 32'h0000_0000);
    wr(A_BAND_RS, 32'h0000_0000);
    wr(A_BAND_ROWS, 32'h0000_0002);
    wr(A_BAND_ON, 32'h0000_0001);
    wr(A_BAND_SEL, 32'h0000_0000);
    rd_chk(A_BAND_CS, 32'h0000_0030);
    rd_chk(A_BAND_STAT, 32'h0000_0001);
    wr(A_USER_SET, 32'h0000_0001);
    frame_chk(16'h0080, 12'h000, 12'h2CF);
    chk({31'h0000_0000, act}, 32'h0000_0001);
    rd_chk(A_BAND_STAT, 32'h0000_0003);
    // Band 0 now reaches past the right edge on purpose.
    wr(A_BAND_CS, 32'h0000_0070);
    @(negedge clk_sys);
    chk({31'h0000_0000, ok}, 32'h0000_0000);
    frame_chk(16'h0100, 12'h110, 12'h2CF);
    chk({31'h0000_0000, act}, 32'h0000_0000);
    wr(A_USER_SET, 32'h0000_0002);
    wr(A_BAND_SEL, 32'h0000_0000);
    rd_chk(A_BAND_CS, 32'h0000_0030);
    @(negedge clk_sys);
    chk({31'h0000_0000, ok}, 32'h0000_0001);
    wr(A_BAND_SEL, 32'h0000_003F);
    rd_chk(A_BAND_SEL, 32'h0000_001F);
    chk({16'h0000, frame_count}, 32'h0000_0003);
    summarize();
  end
endmodule : sroi_window_select_tb_top
`default_nettype wire

// *** rtl/sroi_pkg.sv ***
/*
  Shared constants for the sensor window and band selector: register
  offsets, field bits, alignment masks, size floors and the readout mode.
  Assumes a 32-bit APB master with byte addresses and word-aligned registers.
*/
package sroi_pkg;
  localparam int CW     = 16; // Width of every coordinate field.
  localparam int BANDS  = 32; // Number of horizontal bands.
  localparam int SEL_W  = 5;  // Width of the band index.
  localparam int ADDR_W = 8;  // APB address width.
  localparam int DATA_W = 32; // APB data width.

  // Register byte offsets.
  localparam logic [7:0] A_WIN_COLS   = 8'h00;
  localparam logic [7:0] A_WIN_ROWS   = 8'h04;
  localparam logic [7:0] A_WIN_CS     = 8'h08;
  localparam logic [7:0] A_WIN_RS     = 8'h0C;
  localparam logic [7:0] A_EFF_COLS   = 8'h10;
  localparam logic [7:0] A_EFF_ROWS   = 8'h14;
  localparam logic [7:0] A_LRG_COLS   = 8'h18;
  localparam logic [7:0] A_LRG_ROWS   = 8'h1C;
  localparam logic [7:0] A_BAND_SEL   = 8'h20;
  localparam logic [7:0] A_BAND_ON    = 8'h24;
  localparam logic [7:0] A_BAND_CS    = 8'h28;
  localparam logic [7:0] A_BAND_RS    = 8'h2C;
  localparam logic [7:0] A_BAND_ROWS  = 8'h30;
  localparam logic [7:0] A_BAND_CMN   = 8'h34;
  localparam logic [7:0] A_BAND_STAT  = 8'h38;
  localparam logic [7:0] A_USER_SET   = 8'h3C;

  // Bit positions inside the status and user-set registers.
  localparam int ST_OK_BIT   = 0;
  localparam int ST_ACT_BIT  = 1;
  localparam int US_SAVE_BIT = 0;
  localparam int US_LOAD_BIT = 1;

  // Alignment masks and size floors.
  localparam logic [15:0] COL_MASK = 16'hFFF0;
  localparam logic [15:0] ROW_MASK = 16'hFFFE;
  localparam logic [15:0] MIN_COLS = 16'h0040;
  localparam logic [15:0] MIN_ROWS = 16'h0004;
  localparam logic [15:0] ZERO_C   = 16'h0000;

  // Default effective sensor size.
  localparam logic [15:0] DEF_EFF_COLS = 16'h2C00;
  localparam logic [15:0] DEF_EFF_ROWS = 16'h23F0;

  // Readout mode of the current frame.
  typedef enum logic [0:0] {
    MODE_WINDOW = 1'b0,
    MODE_BANDS  = 1'b1
  } sroi_mode_t;

  // Rounds a written value down to its alignment and up to its floor.
  function automatic logic [15:0] sroi_fit(
    input logic [15:0] v,
    input logic [15:0] mask,
    input logic [15:0] floor_v
  );
    logic [15:0] a;
    a = v & mask;
    return (a < floor_v) ? floor_v : a;
  endfunction : sroi_fit
endpackage : sroi_pkg

// *** rtl/sroi_window_select.sv ***
/*
  Crops each sensor frame either to one window or to a stack of enabled
  horizontal bands of common width, with APB registers for all settings.
  Assumes the pixel stream comes from logic on clk_sys, one pixel per valid,
  with frame start and line start flagged on the first pixel they cover.
*/
// Notes on behaviour
// - Window width rounded to sixteen pixels.
// - Window height rounded to two lines.
// - Window at least 64 by 4.
// - Offsets count from top-left corner zero.
// - Window size resets to sensor maximum.
// - Window pixels pass through unchanged.
// - Sensor and largest extents are read-only.
// - Thirty-two bands chosen by index.
// - Band mode drops pixels outside bands.
// - Band pixels form one output frame.
// - Band writes reach selected band only.
// - All bands share one width.
// - Output is common width, union of enabled band rows.
// - Band column fields multiple of sixteen.
// - Band row fields multiple of two.
// - Read-only flag shows band settings legal.
// - Status shows band readout in use.
// - Band settings saved and restored.
`timescale 1ns/1ps
`default_nettype none
module sroi_window_select #(
  parameter int PIX_W = 12,
  parameter logic [15:0] EFF_COLS = sroi_pkg::DEF_EFF_COLS,
  parameter logic [15:0] EFF_ROWS = sroi_pkg::DEF_EFF_ROWS
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sroi_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sroi_pkg::DATA_W-1:0] pwdata,
  output logic [sroi_pkg::DATA_W-1:0]      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        pix_valid,
  input  wire logic                        pix_frame_start,
  input  wire logic                        pix_line_start,
  input  wire logic [PIX_W-1:0]            pix_data,
  output logic                             out_valid,
  output logic                             out_frame_start,
  output logic                             out_line_start,
  output logic [PIX_W-1:0]                 out_data,
  output logic                             band_settings_ok,
  output logic                             band_readout_active
);
  import sroi_pkg::*;

  // The whole state of the block.
  typedef struct packed {
    logic [CW-1:0]             win_cols;   // Window width.
    logic [CW-1:0]             win_rows;   // Window height.
    logic [CW-1:0]             win_cs;     // Window first column.
    logic [CW-1:0]             win_rs;     // Window first row.
    logic [SEL_W-1:0]          sel;        // Band index in use.
    logic [BANDS-1:0]          on;         // Band enables.
    logic [BANDS-1:0][CW-1:0]  cs;         // Band first columns.
    logic [BANDS-1:0][CW-1:0]  rs;         // Band first rows.
    logic [BANDS-1:0][CW-1:0]  h;          // Band heights.
    logic [CW-1:0]             cmn;        // Common band width.
    logic [BANDS-1:0]          sv_on;      // Saved enables.
    logic [BANDS-1:0][CW-1:0]  sv_cs;      // Saved first columns.
    logic [BANDS-1:0][CW-1:0]  sv_rs;      // Saved first rows.
    logic [BANDS-1:0][CW-1:0]  sv_h;       // Saved heights.
    logic [CW-1:0]             sv_cmn;     // Saved common width.
    logic [CW-1:0]             col;        // Column of the last pixel.
    logic [CW-1:0]             row;        // Row of the last pixel.
    sroi_mode_t                mode;       // Mode of the current frame.
    logic                      sent_frame; // A pixel left this frame.
    logic                      sent_line;  // A pixel left this row.
    logic [DATA_W-1:0]         rdata;      // Read data for the bus.
    logic                      o_valid;    // Output pixel strobe.
    logic                      o_fs;       // Output frame start.
    logic                      o_ls;       // Output line start.
    logic [PIX_W-1:0]          o_data;     // Output pixel value.
  } sroi_state_t;

  sroi_state_t s;
  sroi_state_t next_s;

  // Bus phase decode.
  logic wr_acc;   // Write access cycle.
  logic rd_setup; // Read setup cycle.
  logic mapped;   // Address hits a register.

  // Pixel coordinates of the incoming pixel.
  logic [CW-1:0] cur_col;
  logic [CW-1:0] cur_row;

  // Per-band decode, one entry per band.
  logic [BANDS-1:0] band_good; // Band passes every check.
  logic [BANDS-1:0] row_hit;   // Current row lies in the band.
  logic             all_good;  // Whole band set is legal.
  logic             start_bands;
  sroi_mode_t       cur_mode;
  logic             keep;      // Current pixel leaves the block.

  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  // The slave never waits; an access always ends in its first cycle.
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // Address decode; the map ends at the user-set register.
  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00) && (paddr <= A_USER_SET);
  end

  // Coordinates start at zero at the top-left pixel.
  always_comb
  begin
    cur_col = pix_line_start ? ZERO_C : s.col + 16'h0001;
    cur_row = pix_frame_start ? ZERO_C :
              (pix_line_start ? s.row + 16'h0001 : s.row);
  end

  // One checker and row comparator per band.
  genvar gi;
  generate
    for (gi = 0; gi < BANDS; gi++)
    begin : g_band
      logic [CW:0] col_end;
      logic [CW:0] row_end;
      assign col_end = {1'b0, s.cs[gi]} + {1'b0, s.cmn};
      assign row_end = {1'b0, s.rs[gi]} + {1'b0, s.h[gi]};
      // Disabled bands never spoil the set.
      assign band_good[gi] = ~s.on[gi] |
        ((s.cs[gi][3:0] == 4'h0) & (s.rs[gi][0] == 1'b0) &
         (s.h[gi][0] == 1'b0) & (s.h[gi] != ZERO_C) &
         (col_end <= {1'b0, EFF_COLS}) &
         (row_end <= {1'b0, EFF_ROWS}));
      assign row_hit[gi] = s.on[gi] & (cur_row >= s.rs[gi]) &
                           ({1'b0, cur_row} < row_end);
    end
  endgenerate

  // The common width must be aligned and fit the sensor as well.
  assign all_good = (&band_good) & (|s.on) &
                    (s.cmn[3:0] == 4'h0) & (s.cmn != ZERO_C) &
                    (s.cmn <= EFF_COLS);
  assign start_bands = all_good;

  // Pixel selection in the mode of the current frame.
  always_comb
  begin
    logic [CW:0]    cend;
    logic [SEL_W-1:0] pick;
    logic           hit;
    cend = '0;
    pick = '0;
    hit  = 1'b0;
    cur_mode = s.mode;
    if (pix_frame_start)
    begin
      // Mode is fixed for a whole frame so no frame is half cropped.
      cur_mode = start_bands ? MODE_BANDS : MODE_WINDOW;
    end
    // Lowest-index band wins where bands overlap, so a row leaves once.
    for (int i = BANDS - 1; i >= 0; i--)
    begin
      if (row_hit[i])
      begin
        pick = SEL_W'(i);
        hit  = 1'b1;
      end
    end
    if (cur_mode == MODE_BANDS)
    begin
      // Every band row is cmn pixels wide, so rows stack into one image.
      cend = {1'b0, s.cs[pick]} + {1'b0, s.cmn};
      keep = pix_valid & hit & (cur_col >= s.cs[pick]) &
             ({1'b0, cur_col} < cend);
    end
    else
    begin
      keep = pix_valid &
             (cur_col >= s.win_cs) &
             ({1'b0, cur_col} < ({1'b0, s.win_cs} + {1'b0, s.win_cols})) &
             (cur_row >= s.win_rs) &
             ({1'b0, cur_row} < ({1'b0, s.win_rs} + {1'b0, s.win_rows}));
    end
  end

  // Next-state logic for registers, counters and the output stage.
  always_comb
  begin
    logic [CW-1:0] wv;
    wv = pwdata[CW-1:0];
    next_s = s;
    // Pixel counters follow every valid pixel.
    if (pix_valid)
    begin
      next_s.col = cur_col;
      next_s.row = cur_row;
      if (pix_frame_start)
      begin
        next_s.mode       = cur_mode;
        next_s.sent_frame = 1'b0;
      end
      if (pix_line_start)
      begin
        next_s.sent_line = 1'b0;
      end
    end
    // Values pass untouched, only the strobes decide.
    next_s.o_valid = keep;
    next_s.o_data  = pix_data;
    next_s.o_fs    = keep & (pix_frame_start | ~s.sent_frame);
    next_s.o_ls    = keep & (pix_line_start | ~s.sent_line);
    if (keep)
    begin
      next_s.sent_frame = 1'b1;
      next_s.sent_line  = 1'b1;
    end
    // Register writes take effect in the access cycle.
    if (wr_acc)
    begin
      if (paddr == A_WIN_COLS)
      begin
        next_s.win_cols = sroi_fit(wv, COL_MASK, MIN_COLS);
      end
      else if (paddr == A_WIN_ROWS)
      begin
        next_s.win_rows = sroi_fit(wv, ROW_MASK, MIN_ROWS);
      end
      else if (paddr == A_WIN_CS)
      begin
        next_s.win_cs = wv;
      end
      else if (paddr == A_WIN_RS)
      begin
        next_s.win_rs = wv;
      end
      else if (paddr == A_BAND_SEL)
      begin
        next_s.sel = pwdata[SEL_W-1:0];
      end
      else if (paddr == A_BAND_ON)
      begin
        next_s.on[s.sel] = pwdata[0];
      end
      else if (paddr == A_BAND_CS)
      begin
        next_s.cs[s.sel] = wv & COL_MASK;
      end
      else if (paddr == A_BAND_RS)
      begin
        next_s.rs[s.sel] = wv & ROW_MASK;
      end
      else if (paddr == A_BAND_ROWS)
      begin
        next_s.h[s.sel] = wv & ROW_MASK;
      end
      else if (paddr == A_BAND_CMN)
      begin
        next_s.cmn = wv & COL_MASK;
      end
      else if (paddr == A_USER_SET)
      begin
        // Save wins if both bits are written together.
        if (pwdata[US_SAVE_BIT])
        begin
          next_s.sv_on  = s.on;
          next_s.sv_cs  = s.cs;
          next_s.sv_rs  = s.rs;
          next_s.sv_h   = s.h;
          next_s.sv_cmn = s.cmn;
        end
        else if (pwdata[US_LOAD_BIT])
        begin
          next_s.on  = s.sv_on;
          next_s.cs  = s.sv_cs;
          next_s.rs  = s.sv_rs;
          next_s.h   = s.sv_h;
          next_s.cmn = s.sv_cmn;
        end
      end
    end
    // Read data is captured in the setup cycle and held for the access.
    if (rd_setup)
    begin
      next_s.rdata = '0;
      if (paddr == A_WIN_COLS)
        next_s.rdata[CW-1:0] = s.win_cols;
      else if (paddr == A_WIN_ROWS)
        next_s.rdata[CW-1:0] = s.win_rows;
      else if (paddr == A_WIN_CS)
        next_s.rdata[CW-1:0] = s.win_cs;
      else if (paddr == A_WIN_RS)
        next_s.rdata[CW-1:0] = s.win_rs;
      else if (paddr == A_EFF_COLS)
        next_s.rdata[CW-1:0] = EFF_COLS;
      else if (paddr == A_EFF_ROWS)
        next_s.rdata[CW-1:0] = EFF_ROWS;
      else if (paddr == A_LRG_COLS)
        next_s.rdata[CW-1:0] = EFF_COLS - s.win_cs;
      else if (paddr == A_LRG_ROWS)
        next_s.rdata[CW-1:0] = EFF_ROWS - s.win_rs;
      else if (paddr == A_BAND_SEL)
        next_s.rdata[SEL_W-1:0] = s.sel;
      else if (paddr == A_BAND_ON)
        next_s.rdata[0] = s.on[s.sel];
      else if (paddr == A_BAND_CS)
        next_s.rdata[CW-1:0] = s.cs[s.sel];
      else if (paddr == A_BAND_RS)
        next_s.rdata[CW-1:0] = s.rs[s.sel];
      else if (paddr == A_BAND_ROWS)
        next_s.rdata[CW-1:0] = s.h[s.sel];
      else if (paddr == A_BAND_CMN)
        next_s.rdata[CW-1:0] = s.cmn;
      else if (paddr == A_BAND_STAT)
      begin
        next_s.rdata[ST_OK_BIT]  = all_good;
        next_s.rdata[ST_ACT_BIT] = (s.mode == MODE_BANDS);
      end
    end
  end

  // State register; window size comes up at the sensor size.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s          <= '0;
      s.win_cols <= EFF_COLS;
      s.win_rows <= EFF_ROWS;
      s.mode     <= MODE_WINDOW;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata              = s.rdata;
  assign out_valid           = s.o_valid;
  assign out_frame_start     = s.o_fs;
  assign out_line_start      = s.o_ls;
  assign out_data            = s.o_data;
  assign band_settings_ok    = all_good;
  assign band_readout_active = (s.mode == MODE_BANDS);

  // A write access to one register address.
  sequence apb_wr_seq(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // The first pixel of a frame.
  sequence frame_seq;
    pix_valid && pix_frame_start;
  endsequence

  reset_size_a: assert property (@(posedge clk_sys)
    $fell(reset) |-> s.win_cols == EFF_COLS && s.win_rows == EFF_ROWS)
    else $error("Window size not at maximum after reset.");
  col_align_a: assert property (@(posedge clk_sys) disable iff (reset)
    apb_wr_seq(A_WIN_COLS) |=> s.win_cols[3:0] == 4'h0)
    else $error("Window width not a multiple of sixteen.");
  row_align_a: assert property (@(posedge clk_sys) disable iff (reset)
    apb_wr_seq(A_WIN_ROWS) |=> s.win_rows[0] == 1'b0)
    else $error("Window height not even.");
  min_size_a: assert property (@(posedge clk_sys) disable iff (reset)
    s.win_cols >= MIN_COLS && s.win_rows >= MIN_ROWS)
    else $error("Window below minimum size.");
  band_align_a: assert property (@(posedge clk_sys) disable iff (reset)
    apb_wr_seq(A_BAND_CMN) |=> s.cmn[3:0] == 4'h0 && $stable(s.on))
    else $error("Common band width misaligned.");
  band_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    apb_wr_seq(A_BAND_ROWS) |=> s.h[$past(s.sel)] == ($past(pwdata[15:0]) & ROW_MASK))
    else $error("Band height not written to selected band.");
  pass_value_a: assert property (@(posedge clk_sys) disable iff (reset)
    pix_valid ##1 out_valid |-> out_data == $past(pix_data))
    else $error("Output pixel value altered.");
  invalid_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    frame_seq and !all_good |=> !band_readout_active)
    else $error("Band readout entered with illegal settings.");
  status_on_a: assert property (@(posedge clk_sys) disable iff (reset)
    frame_seq and all_good |=> band_readout_active)
    else $error("Band readout not reported active.");
  restore_a: assert property (@(posedge clk_sys) disable iff (reset)
    apb_wr_seq(A_USER_SET) and !pwdata[US_SAVE_BIT] and pwdata[US_LOAD_BIT]
    |=> s.on == $past(s.sv_on) && s.cmn == $past(s.sv_cmn))
    else $error("Saved band settings not restored.");
  no_stray_a: assert property (@(posedge clk_sys) disable iff (reset)
    !pix_valid |=> !out_valid)
    else $error("Output pixel without input pixel.");
endmodule : sroi_window_select
`default_nettype wire
